// *** rtl/sptc_top.sv ***
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sptc_top
	import sptc_pkg::*;
#(
	parameter int NCHILD = 8,
	parameter int CIDW = 3,
	parameter int MS_CYC = MS_CYCLES
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rf_rx,
	input wire logic poll_ack,
	input wire logic pin_wake,
	output logic awake_indicator,
	output logic poll_req,
	output logic sample_req,
	output logic parent_search,
	input wire logic child_poll,
	input wire logic child_join,
	input wire logic [CIDW-1:0] child_id,
	output logic child_drop,
	input wire logic tx_ack,
	output logic tx_attempt,
	output logic tx_busy,
	output logic tx_fail,
	output logic tx_done,
	input wire logic buf_store,
	input wire logic buf_take,
	output logic buf_expire
);
	logic tick_ms, tick_10ms;
	logic [15:0] sp_q, sp_d, sn_q, sn_d, st_q, st_d, ir_q, ir_d, po_q, po_d;
	logic [7:0] nh_q, nh_d, opt_q, opt_d;
	logic [2:0] sel_q, sel_d;
	logic [3:0] line1_q, line1_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d, m, mw;
	logic wb_wr, sleep_now, tx_start, lost_clr;
	logic [39:0] poll_to_ms, tx_to_ms, hold_raw;
	logic [15:0] buf_ms;
	logic [31:0] sleep_len;
	sptc_ed_t st_ed_q, st_ed_d;
	logic [15:0] cyc_q, cyc_d, ivl_q, ivl_d, reg_ivl;
	logic awake_q, awake_d, pend_q, pend_d, lost_q, lost_d;
	logic [1:0] miss_q, miss_d;
	logic poll_q, poll_d, smp_q, smp_d, srch_q, srch_d;
	logic sl_load, wk_load, wk_stop, pl_load, sm_load, sm_stop;
	logic sl_exp, wk_run, wk_exp, pl_exp, sm_exp, pl_run, sm_run, sl_run;
	logic cyclic, ext, smp_en, ind;
	logic [NCHILD-1:0] valid_q, valid_d, c_load, c_exp;
	logic drop_q, drop_d;
	logic [7:0] free_cnt;
	logic [1:0] att_q, att_d;
	logic busy_q, busy_d, fail_q, fail_d, done_q, done_d, txa_q, txa_d;
	logic tx_load, tx_stop, tx_exp, tx_run, bf_run;

	sptc_tick #(.MS_CYC(MS_CYC), .TEN(TEN_MS_TICKS)) u_tick (
		.mclk(mclk), .rst(rst), .tick_ms(tick_ms), .tick_10ms(tick_10ms));

	// derived timeouts in ms
	always_comb
	begin
		poll_to_ms = 40'(sp_q) * 40'(sn_q) * 40'(POLL_TO_MULT * SP_UNIT_MS);
		if (poll_to_ms < 40'(POLL_TO_MIN_MS))
			poll_to_ms = 40'(POLL_TO_MIN_MS);
		tx_to_ms = 40'(TX_MULT) * (40'(TX_HOP_MS) * 40'(nh_q)
			+ 40'(HOLD_MS_PER_SP) * 40'(sp_q));
		hold_raw = 40'(HOLD_MS_PER_SP) * 40'(sp_q);
		if (hold_raw < 40'(BUF_MIN_MS))
			buf_ms = 16'(BUF_MIN_MS);
		else if (hold_raw > 40'(BUF_MAX_MS))
			buf_ms = 16'(BUF_MAX_MS);
		else
			buf_ms = hold_raw[15:0];
		ext = (opt_q == OPT_EXT) || (opt_q == OPT_EXT_WAKE);
		sleep_len = ext ? 32'(sp_q) * 32'(sn_q) : 32'(sp_q);
		cyclic = (sel_q == SEL_CYCLIC) || (sel_q == SEL_CYCLIC_PIN);
		smp_en = (ir_q != 16'h0)
			&& ((line1_q == LINE_MON) || (line1_q == LINE_ANALOG));
	end

	// wishbone slave: ack one cycle after the request, writes land on the ack edge
	always_comb
	begin
		m = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
			{8{wb_sel_i[0]}}};
		mw = ({12'h0, line1_q, opt_q, 5'h0, sel_q} & ~m) | (wb_dat_i & m);
		wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
		ack_d = wb_cyc_i && wb_stb_i && !ack_q;
		sp_d = sp_q;
		sn_d = sn_q;
		st_d = st_q;
		ir_d = ir_q;
		po_d = po_q;
		nh_d = nh_q;
		sel_d = sel_q;
		opt_d = opt_q;
		line1_d = line1_q;
		sleep_now = 1'b0;
		tx_start = 1'b0;
		lost_clr = 1'b0;
		if (wb_wr)
		begin
			case (wb_adr_i)
			OFS_SP: sp_d = (sp_q & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
			OFS_SN: sn_d = (sn_q & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
			OFS_ST: st_d = (st_q & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
			OFS_IR: ir_d = (ir_q & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
			OFS_PO: po_d = (po_q & ~m[15:0]) | (wb_dat_i[15:0] & m[15:0]);
			OFS_NH: nh_d = (nh_q & ~m[7:0]) | (wb_dat_i[7:0] & m[7:0]);
			OFS_MODE:
			begin
				sel_d = mw[2:0];
				opt_d = mw[15:8];
				line1_d = mw[19:16];
			end
			OFS_CMD:
			begin
				sleep_now = wb_sel_i[0] && wb_dat_i[CMD_SLEEP_BIT];
				tx_start = wb_sel_i[0] && wb_dat_i[CMD_TX_BIT];
				lost_clr = wb_sel_i[0] && wb_dat_i[CMD_LOSTCLR_BIT];
			end
			default: ;
			endcase
		end
		// reads are sampled when ack rises; unmapped offsets read zero
		rdat_d = rdat_q;
		if (ack_d)
		begin
			case (wb_adr_i)
			OFS_SP: rdat_d = {16'h0, sp_q};
			OFS_SN: rdat_d = {16'h0, sn_q};
			OFS_ST: rdat_d = {16'h0, st_q};
			OFS_IR: rdat_d = {16'h0, ir_q};
			OFS_PO: rdat_d = {16'h0, po_q};
			OFS_NH: rdat_d = {24'h0, nh_q};
			OFS_MODE: rdat_d = {12'h0, line1_q, opt_q, 5'h0, sel_q};
			OFS_STAT: rdat_d = {16'h0, free_cnt, st_ed_q, lost_q, done_q,
				fail_q, busy_q, 1'b0, awake_q};
			OFS_VALID: rdat_d = 32'(valid_q);
			OFS_POLLTO: rdat_d = poll_to_ms[31:0];
			OFS_TXTO: rdat_d = tx_to_ms[31:0];
			OFS_BUFTO: rdat_d = {16'h0, buf_ms};
			default: rdat_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sp_q <= RST_SP;
			sn_q <= RST_SN;
			st_q <= RST_ST;
			ir_q <= RST_IR;
			po_q <= RST_PO;
			nh_q <= RST_NH;
			sel_q <= 3'h0;
			opt_q <= 8'h00;
			line1_q <= 4'h0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0;
		end
		else
		begin
			sp_q <= sp_d;
			sn_q <= sn_d;
			st_q <= st_d;
			ir_q <= ir_d;
			po_q <= po_d;
			nh_q <= nh_d;
			sel_q <= sel_d;
			opt_q <= opt_d;
			line1_q <= line1_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// end device timers: sleep in 10 ms units, the rest in ms
	sptc_down_timer #(.W(32)) u_sleep (.mclk(mclk), .rst(rst),
		.load(sl_load), .stop(1'b0), .tick(tick_10ms), .value(sleep_len),
		.running(sl_run), .expired(sl_exp));
	sptc_down_timer #(.W(16)) u_wake (.mclk(mclk), .rst(rst),
		.load(wk_load), .stop(wk_stop), .tick(tick_ms), .value(st_q),
		.running(wk_run), .expired(wk_exp));
	sptc_down_timer #(.W(16)) u_poll (.mclk(mclk), .rst(rst),
		.load(pl_load), .stop(sl_load), .tick(tick_ms), .value(ivl_d),
		.running(pl_run), .expired(pl_exp));
	sptc_down_timer #(.W(16)) u_smp (.mclk(mclk), .rst(rst),
		.load(sm_load), .stop(sm_stop), .tick(tick_ms), .value(ir_q),
		.running(sm_run), .expired(sm_exp));

	// end device sleep, wake, poll and sample sequencing
	always_comb
	begin
		st_ed_d = st_ed_q;
		cyc_d = cyc_q;
		awake_d = awake_q;
		sl_load = 1'b0;
		wk_load = 1'b0;
		wk_stop = 1'b0;
		poll_d = 1'b0;
		smp_d = 1'b0;
		ind = 1'b0;
		reg_ivl = wk_run ? 16'(POLL_WAKE_MS) : po_q;
		case (st_ed_q)
		ED_OFF:
		begin
			awake_d = 1'b1;
			poll_d = pl_exp || !pl_run;
			if (cyclic)
			begin
				st_ed_d = ED_SLEEP;
				sl_load = 1'b1;
				awake_d = 1'b0;
				poll_d = 1'b0;
			end
		end
		ED_SLEEP:
		begin
			awake_d = 1'b0;
			if (!cyclic)
				st_ed_d = ED_OFF;
			else if (sl_exp || (sel_q == SEL_CYCLIC_PIN && pin_wake))
			begin
				ind = ext || pin_wake || (cyc_q + 16'h1 >= sn_q);
				cyc_d = ind ? 16'h0 : cyc_q + 16'h1;
				awake_d = ind;
				st_ed_d = ED_WAKE;
				poll_d = 1'b1;
				wk_load = ind && (opt_q == OPT_EXT_WAKE || smp_en);
				smp_d = ind && smp_en;
			end
		end
		ED_WAKE:
		begin
			if (sleep_now || wk_exp || (!wk_run && pl_exp))
			begin
				st_ed_d = ED_SLEEP;
				sl_load = 1'b1;
				wk_stop = 1'b1;
				awake_d = 1'b0;
			end
			else
			begin
				if (rf_rx)
				begin
					awake_d = 1'b1;
					wk_load = 1'b1;
				end
				poll_d = wk_run && pl_exp;
				smp_d = wk_run && smp_en && sm_exp
					&& (ir_q != SAMPLE_ONCE);
			end
		end
		default:
			st_ed_d = ED_OFF;
		endcase
		// data restarts the poll timer so the short interval acts at once
		pl_load = poll_d || (rf_rx && st_ed_q != ED_SLEEP && !sl_load);
		sm_load = smp_d && (ir_q != SAMPLE_ONCE);
		sm_stop = sl_load;
		// adaptive polling: fast after data, doubling back to regular
		ivl_d = ivl_q;
		if (rf_rx)
			ivl_d = 16'(ADAPT_MIN_MS);
		else if (poll_d && ivl_q < reg_ivl)
			ivl_d = (ivl_q > (reg_ivl >> 1)) ? reg_ivl : ivl_q << 1;
		else if (poll_d)
			ivl_d = reg_ivl;
		// parent link watch: new poll while the previous is unacked counts a miss
		pend_d = pend_q && !poll_ack;
		miss_d = poll_ack ? 2'h0 : miss_q;
		srch_d = 1'b0;
		if (poll_d)
		begin
			pend_d = 1'b1;
			if (pend_q && !poll_ack)
			begin
				if (miss_q == 2'(MISS_LIMIT - 1))
				begin
					srch_d = 1'b1;
					miss_d = 2'h0;
				end
				else
					miss_d = miss_q + 2'h1;
			end
		end
		lost_d = srch_d || (lost_q && !lost_clr);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_ed_q <= ED_OFF;
			cyc_q <= 16'h0;
			awake_q <= 1'b0;
			ivl_q <= 16'(POLL_WAKE_MS);
			pend_q <= 1'b0;
			miss_q <= 2'h0;
			poll_q <= 1'b0;
			smp_q <= 1'b0;
			srch_q <= 1'b0;
			lost_q <= 1'b0;
		end
		else
		begin
			st_ed_q <= st_ed_d;
			cyc_q <= cyc_d;
			awake_q <= awake_d;
			ivl_q <= ivl_d;
			pend_q <= pend_d;
			miss_q <= miss_d;
			poll_q <= poll_d;
			smp_q <= smp_d;
			srch_q <= srch_d;
			lost_q <= lost_d;
		end
	end

	assign awake_indicator = awake_q;
	assign poll_req = poll_q;
	assign sample_req = smp_q;
	assign parent_search = srch_q;

	// parent side: one poll timeout timer per child table entry
	genvar gi;
	generate
		for (gi = 0; gi < NCHILD; gi++)
		begin : g_child
			assign c_load[gi] = (child_poll || child_join)
				&& (child_id == CIDW'(gi));
			sptc_down_timer #(.W(40)) u_ct (.mclk(mclk), .rst(rst),
				.load(c_load[gi]), .stop(1'b0), .tick(tick_ms),
				.value(poll_to_ms), .running(), .expired(c_exp[gi]));
		end
	endgenerate

	sptc_down_timer #(.W(40)) u_tx (.mclk(mclk), .rst(rst),
		.load(tx_load), .stop(tx_stop), .tick(tick_ms), .value(tx_to_ms),
		.running(tx_run), .expired(tx_exp));
	// buffered frames are held long enough for short sleepers to poll
	sptc_down_timer #(.W(16)) u_buf (.mclk(mclk), .rst(rst),
		.load(buf_store), .stop(buf_take), .tick(tick_ms), .value(buf_ms),
		.running(bf_run), .expired(buf_expire));

	// child table upkeep and transmission retries
	always_comb
	begin
		valid_d = (valid_q & ~c_exp) | c_load;
		drop_d = |(c_exp & ~c_load);
		free_cnt = 8'h0;
		for (int i = 0; i < NCHILD; i++)
			free_cnt = free_cnt + {7'h0, !valid_q[i]};
		att_d = att_q;
		busy_d = busy_q;
		fail_d = fail_q;
		done_d = done_q;
		txa_d = 1'b0;
		tx_load = 1'b0;
		tx_stop = 1'b0;
		if (tx_start && !busy_q)
		begin
			busy_d = 1'b1;
			fail_d = 1'b0;
			done_d = 1'b0;
			att_d = 2'h1;
			tx_load = 1'b1;
			txa_d = 1'b1;
		end
		else if (busy_q && tx_ack)
		begin
			busy_d = 1'b0;
			done_d = 1'b1;
			tx_stop = 1'b1;
		end
		else if (busy_q && tx_exp)
		begin
			if (att_q < 2'(1 + TX_RETRIES))
			begin
				att_d = att_q + 2'h1;
				tx_load = 1'b1;
				txa_d = 1'b1;
			end
			else
			begin
				busy_d = 1'b0;
				fail_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			valid_q <= '0;
			drop_q <= 1'b0;
			att_q <= 2'h0;
			busy_q <= 1'b0;
			fail_q <= 1'b0;
			done_q <= 1'b0;
			txa_q <= 1'b0;
		end
		else
		begin
			valid_q <= valid_d;
			drop_q <= drop_d;
			att_q <= att_d;
			busy_q <= busy_d;
			fail_q <= fail_d;
			done_q <= done_d;
			txa_q <= txa_d;
		end
	end

	assign child_drop = drop_q;
	assign tx_attempt = txa_q;
	assign tx_busy = busy_q;
	assign tx_fail = fail_q;
	assign tx_done = done_q;

	// checks on the timing logic
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack not given next cycle");
	a_child_drop_slot: assert property (|(c_exp & ~c_load) |=> child_drop
		&& (valid_q & $past(c_exp & ~c_load)) == '0)
		else $error("child not dropped");
	a_poll_to_floor: assert property (poll_to_ms >= 40'(POLL_TO_MIN_MS))
		else $error("poll timeout below floor");
	a_poll_to_mult: assert property (sp_q * sn_q >= 32'd200
		|-> poll_to_ms == 40'(sp_q) * 40'(sn_q) * 40'd30)
		else $error("poll timeout product wrong");
	a_tx_attempt_max: assert property (busy_q && tx_exp && !tx_ack
		&& att_q == 2'd3 |=> !tx_busy && tx_fail && !tx_attempt)
		else $error("attempt after the last retry");
	a_tx_ack_stop: assert property (busy_q && tx_ack && !tx_start
		|=> !tx_busy && tx_done ##1 !tx_attempt) else $error("ack ignored");
	a_tx_to_value: assert property (tx_load |-> tx_to_ms ==
		40'd150 * 40'(nh_q) + 40'd36 * 40'(sp_q))
		else $error("attempt timeout wrong");
	a_buf_clamp: assert property (buf_ms >= 16'd1200 && buf_ms <= 16'd30000)
		else $error("buffer hold out of range");
	a_sleep_now_enter: assert property (st_ed_q == ED_WAKE && sleep_now
		|=> st_ed_q == ED_SLEEP && !awake_indicator)
		else $error("sleep_now ignored");
	a_sleep_quiet: assert property (st_ed_q == ED_SLEEP && $past(st_ed_q)
		== ED_SLEEP |-> !poll_req && !sample_req)
		else $error("activity while asleep");
	a_search_after3: assert property (parent_search |-> $past(miss_q)
		== 2'd2) else $error("search without three misses");
	c_tx_fail: cover property (busy_q ##1 !busy_q && tx_fail);
	c_child_drop: cover property (child_drop);
	c_parent_lost: cover property (parent_search);
	c_wake_sample: cover property (st_ed_q == ED_WAKE && sample_req);
endmodule : sptc_top
`default_nettype wire

// *** rtl/sptc_pkg.sv ***
// Overview of operation
// - parent timestamps each child's latest poll and drops silent children after timeout.
// - child poll timeout is three times sleep_period by sleep_count, at least 5 s.
// - free child entry count can be read at any time.
// - after RF data, poll fast, then lengthen interval stepwise back to poll_rate, or to 100 ms while wake timer runs.
// - unacknowledged transmission is resent at most twice more; acknowledgment stops it.
// - per-attempt timeout is 3 times (50 times hop_limit plus 1.2 times sleep_period).
// - awake indicator asserts once per sleep_count cycles, or sooner on RF data.
// - sleep_select 4 means cyclic sleep; 5 adds wake from the sleep request pin.
// - sleep_options 0x04 sleeps sleep_period times sleep_count before waking.
// - sleep_options 0x06 extends sleep and stays awake full wake_time after waking.
// - sample_interval 0x800 sends exactly one sample after waking.
// - while wake timer runs, sample every sample_interval; stop when it expires.
// - sampling needs an enabled line; line value 3 is a monitored input.
// - sleep_now command enters sleep at once, ignoring the wake timer.
// - children sleeping under 30 s stay reachable through parent buffering.
// - parent buffers child data 1.2 times sleep_period, clamped to 1.2..30 s.
// - while wake timer runs, poll parent every 100 ms; stop when it expires.
// - three consecutive unacknowledged polls mean parent lost; start parent search.
package sptc_pkg;
	// clock and tick timing
	localparam int CLK_MHZ = 250;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / 1000 * CLK_MHZ / 1000;
	localparam int TEN_MS_TICKS = 10;
	// timeout arithmetic, all results in ms
	localparam int SP_UNIT_MS = 10;
	localparam int POLL_TO_MULT = 3;
	localparam int POLL_TO_MIN_S = 5;
	localparam int POLL_TO_MIN_MS = POLL_TO_MIN_S * 1000;
	localparam int TX_MULT = 3;
	localparam int TX_HOP_MS = 50;
	localparam int HOLD_NUM = 12;
	localparam int HOLD_DEN = 10;
	localparam int HOLD_MS_PER_SP = HOLD_NUM * SP_UNIT_MS / HOLD_DEN;
	localparam int BUF_MIN_MS = 1200;
	localparam int BUF_MAX_S = 30;
	localparam int BUF_MAX_MS = BUF_MAX_S * 1000;
	localparam int POLL_WAKE_MS = 100;
	localparam int ADAPT_MIN_MS = 10;
	localparam int MISS_LIMIT = 3;
	localparam int TX_RETRIES = 2;
	// mode encodings
	localparam logic [2:0] SEL_CYCLIC = 3'h4;
	localparam logic [2:0] SEL_CYCLIC_PIN = 3'h5;
	localparam logic [7:0] OPT_EXT = 8'h04;
	localparam logic [7:0] OPT_EXT_WAKE = 8'h06;
	localparam logic [15:0] SAMPLE_ONCE = 16'h0800;
	localparam logic [3:0] LINE_ANALOG = 4'h2;
	localparam logic [3:0] LINE_MON = 4'h3;
	// register byte offsets
	localparam logic [7:0] OFS_SP = 8'h00;
	localparam logic [7:0] OFS_SN = 8'h04;
	localparam logic [7:0] OFS_ST = 8'h08;
	localparam logic [7:0] OFS_IR = 8'h0C;
	localparam logic [7:0] OFS_PO = 8'h10;
	localparam logic [7:0] OFS_NH = 8'h14;
	localparam logic [7:0] OFS_MODE = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1C;
	localparam logic [7:0] OFS_STAT = 8'h20;
	localparam logic [7:0] OFS_VALID = 8'h24;
	localparam logic [7:0] OFS_POLLTO = 8'h28;
	localparam logic [7:0] OFS_TXTO = 8'h2C;
	localparam logic [7:0] OFS_BUFTO = 8'h30;
	// command bits
	localparam int CMD_SLEEP_BIT = 0;
	localparam int CMD_TX_BIT = 1;
	localparam int CMD_LOSTCLR_BIT = 2;
	// reset values
	localparam logic [15:0] RST_SP = 16'h0020;
	localparam logic [15:0] RST_SN = 16'h0001;
	localparam logic [15:0] RST_ST = 16'h1388;
	localparam logic [15:0] RST_IR = 16'h0000;
	localparam logic [15:0] RST_PO = 16'h0064;
	localparam logic [7:0] RST_NH = 8'h1E;
	// end device states, gray along off, sleep, wake
	typedef enum logic [1:0] {
		ED_OFF = 2'b00,
		ED_SLEEP = 2'b01,
		ED_WAKE = 2'b11
	} sptc_ed_t;
endpackage : sptc_pkg

// *** rtl/sptc_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
module sptc_tick
	import sptc_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES,
	parameter int TEN = TEN_MS_TICKS
)
(
	input wire logic mclk,
	input wire logic rst,
	output logic tick_ms,
	output logic tick_10ms
);
	logic [31:0] cnt_q, cnt_d;
	logic [7:0] div_q, div_d;
	logic ms_q, ms_d, ten_q, ten_d;

	// one prescaler feeds every timer so all counts share one time base
	always_comb
	begin
		cnt_d = cnt_q + 32'h1;
		div_d = div_q;
		ms_d = 1'b0;
		ten_d = 1'b0;
		if (cnt_q == 32'(MS_CYC - 1))
		begin
			cnt_d = 32'h0;
			ms_d = 1'b1;
			div_d = div_q + 8'h1;
			if (div_q == 8'(TEN - 1))
			begin
				div_d = 8'h0;
				ten_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 32'h0;
			div_q <= 8'h0;
			ms_q <= 1'b0;
			ten_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			div_q <= div_d;
			ms_q <= ms_d;
			ten_q <= ten_d;
		end
	end

	assign tick_ms = ms_q;
	assign tick_10ms = ten_q;
endmodule : sptc_tick
`default_nettype wire

// *** rtl/sptc_down_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sptc_down_timer
#(
	parameter int W = 16
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic load,
	input wire logic stop,
	input wire logic tick,
	input wire logic [W-1:0] value,
	output logic running,
	output logic expired
);
	logic [W-1:0] cnt_q, cnt_d;
	logic exp_q, exp_d;

	// load beats stop beats tick; a zero load still waits one tick
	always_comb
	begin
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (load)
			cnt_d = (value == '0) ? W'(1) : value;
		else if (stop)
			cnt_d = '0;
		else if (tick && cnt_q != '0)
		begin
			cnt_d = cnt_q - W'(1);
			exp_d = (cnt_q == W'(1));
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			exp_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			exp_q <= exp_d;
		end
	end

	assign running = (cnt_q != '0);
	assign expired = exp_q;
endmodule : sptc_down_timer
`default_nettype wire

// *** tb/sptc_parent_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sptc_parent_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic poll_req,
	input wire logic tx_attempt,
	input wire logic ack_en,
	input wire logic slow,
	output logic poll_ack,
	output logic tx_ack
);
	int pd;
	int td;
	// parent side: answers polls and attempts only while ack_en is high
	// slow mode stretches the answer so the sender really has to wait
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pd <= 0;
			td <= 0;
			poll_ack <= 1'b0;
			tx_ack <= 1'b0;
		end
		else
		begin
			poll_ack <= (pd == 1) && ack_en;
			tx_ack <= (td == 1);
			pd <= poll_req ? (slow ? 10 : 2) : (pd > 0 ? pd - 1 : 0);
			td <= (tx_attempt && ack_en) ? (slow ? 30 : 2) :
				(td > 0 ? td - 1 : 0);
		end
	end
endmodule : sptc_parent_model
`default_nettype wire

// *** tb/tb_sptc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sptc_top;
	import sptc_pkg::*;
	localparam int MSC = 2;
	localparam logic [7:0] rof [6] = '{OFS_SP, OFS_SN, OFS_ST, OFS_IR,
		OFS_PO, OFS_NH};
	localparam logic [31:0] rrv [6] = '{{16'h0, RST_SP}, {16'h0, RST_SN},
		{16'h0, RST_ST}, {16'h0, RST_IR}, {16'h0, RST_PO}, {24'h0, RST_NH}};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [2:0] cid = 3'h0;
	logic join_p = 1'b0;
	logic store_p = 1'b0;
	logic ack_en = 1'b0;
	logic slow = 1'b0;
	logic rx_p = 1'b0;
	logic [31:0] dat_o;
	logic ack, awake, preq, sreq, psearch, drop, pack, tack;
	logic tatt, tbusy, tfail, tdone, bexp;
	logic [63:0] q[$];
	int err_total = 0;
	int check_count = 0;
	int n_att = 0;
	int n_poll = 0;
	int n_ind = 0;
	int n_smp = 0;
	int n_srch = 0;
	int t;
	logic [31:0] v;
	// shortened millisecond tick keeps the long timeouts affordable
	sptc_top #(.MS_CYC(MSC)) i_dut (.mclk(mclk), .rst(rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.rf_rx(rx_p), .poll_ack(pack), .pin_wake(1'b0),
		.awake_indicator(awake), .poll_req(preq), .sample_req(sreq),
		.parent_search(psearch), .child_poll(1'b0), .child_join(join_p),
		.child_id(cid), .child_drop(drop), .tx_ack(tack),
		.tx_attempt(tatt), .tx_busy(tbusy), .tx_fail(tfail),
		.tx_done(tdone), .buf_store(store_p), .buf_take(1'b0),
		.buf_expire(bexp));
	sptc_parent_model i_par (.mclk(mclk), .rst(rst), .poll_req(preq),
		.tx_attempt(tatt), .ack_en(ack_en), .slow(slow),
		.poll_ack(pack), .tx_ack(tack));
	// free running bench clock
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	task report_and_stop;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one classic cycle; a read leaves its mask and expected word queued
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= w ? d : 32'h0;
		if (!w)
			q.push_back({m, d});
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (ack !== 1'b1 && k < 50);
		if (k >= 50)
			chk(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask : wb
	// bounded wait on one event line, elapsed edges left in t
	task wait_ev(input int s, input int lim);
		logic [3:0] ev;
		t = 0;
		ev = 4'h0;
		while (ev[s] !== 1'b1 && t < lim)
		begin
			@(posedge mclk);
			t++;
			ev = {bexp, drop, tdone, tfail};
		end
		if (t >= lim)
			chk(32'h0, 32'h1);
	endtask : wait_ev
	// bounded wait until n polls were counted since the last clear
	task wait_poll(input int n);
		t = 0;
		while (n_poll < n && t < 4000)
		begin
			@(posedge mclk);
			t++;
		end
		if (t >= 4000)
			chk(32'h0, 32'h1);
	endtask : wait_poll
	// read answers are matched against the oldest note; attempts counted
	always @(posedge mclk)
	begin
		if (ack === 1'b1 && !we && q.size() > 0)
		begin
			chk(dat_o & q[0][63:32], q[0][31:0]);
			void'(q.pop_front());
		end
		if (tatt === 1'b1)
			n_att++;
		if (preq === 1'b1)
		begin
			n_poll++;
			if (awake === 1'b1)
				n_ind++;
		end
		if (sreq === 1'b1)
			n_smp++;
		if (psearch === 1'b1)
			n_srch++;
	end
	// watchdog sized well past the longest scenario
	initial
	begin
		repeat (40000) @(posedge mclk);
		err_total++;
		report_and_stop;
	end
	initial
	begin
		void'($urandom(32'h1AE8B0FD));
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values, then an unmapped place reads zero
		foreach (rof[i])
			wb(1'b0, rof[i], rrv[i], 32'h0000FFFF);
		wb(1'b0, 8'hFC, 32'h0, 32'hFFFFFFFF);
		wb(1'b0, OFS_STAT, 32'h0800, 32'h0000FF00);
		// random sleep_count; a large sleep_period clamps the buffer hold at 30 s
		v = $urandom_range(8, 1);
		wb(1'b1, OFS_SP, 32'h00C8, 32'h0);
		wb(1'b1, OFS_SN, v, 32'h0);
		wb(1'b0, OFS_POLLTO, 32'(6000 * v), 32'hFFFFFFFF);
		wb(1'b0, OFS_BUFTO, 32'h0960, 32'hFFFFFFFF);
		wb(1'b1, OFS_SP, 32'h0BB8, 32'h0);
		wb(1'b0, OFS_BUFTO, 32'h7530, 32'hFFFFFFFF);
		wb(1'b1, OFS_SP, 32'h0001, 32'h0);
		wb(1'b1, OFS_SN, 32'h0001, 32'h0);
		wb(1'b1, OFS_NH, 32'h0001, 32'h0);
		wb(1'b0, OFS_POLLTO, 32'h1388, 32'hFFFFFFFF);
		wb(1'b0, OFS_TXTO, 32'h00BA, 32'hFFFFFFFF);
		wb(1'b0, OFS_BUFTO, 32'h04B0, 32'hFFFFFFFF);
		// no acks: first send plus two resends, then failure
		n_att = 0;
		wb(1'b1, OFS_CMD, 32'h2, 32'h0);
		wait_ev(0, 2000);
		chk(32'(n_att), 32'h3);
		// the parent stayed silent so far, so the link is marked lost
		wb(1'b0, OFS_STAT, 32'h28, 32'h3C);
		chk(32'(n_srch > 0), 32'h1);
		// slow ack: one attempt finishes the transfer
		ack_en <= 1'b1;
		slow <= 1'b1;
		n_att = 0;
		wb(1'b1, OFS_CMD, 32'h2, 32'h0);
		wait_ev(1, 400);
		chk(32'(n_att), 32'h1);
		wb(1'b0, OFS_STAT, 32'h10, 32'h1C);
		// buffered frame dropped after the clamped hold time
		store_p <= 1'b1;
		@(posedge mclk);
		store_p <= 1'b0;
		wait_ev(3, 3000);
		chk(32'(t inside {[2396:2408]}), 32'h1);
		// polls are answered now, so a cleared lost flag stays clear
		wb(1'b1, OFS_CMD, 32'h4, 32'h0);
		wb(1'b0, OFS_STAT, 32'h10, 32'h3C);
		// a joined child that never polls expires at the 5 s floor
		cid <= 3'h2;
		join_p <= 1'b1;
		@(posedge mclk);
		join_p <= 1'b0;
		wb(1'b0, OFS_STAT, 32'h0700, 32'h0000FF00);
		wait_ev(2, 12000);
		chk(32'(t inside {[9990:10006]}), 32'h1);
		wb(1'b0, OFS_STAT, 32'h0800, 32'h0000FF00);
		// cyclic sleep: one poll per wake, indication every third wake
		wb(1'b1, OFS_SN, 32'h0003, 32'h0);
		wb(1'b1, OFS_MODE, {29'h0, SEL_CYCLIC}, 32'h0);
		@(posedge mclk);
		n_poll = 0;
		n_ind = 0;
		n_smp = 0;
		wait_poll(6);
		chk(32'(n_ind), 32'h2);
		// extended sleep with wake time, one sample, data speeds polling
		wb(1'b1, OFS_IR, {16'h0, SAMPLE_ONCE}, 32'h0);
		wb(1'b1, OFS_MODE, 32'h00030604, 32'h0);
		wait_poll(7);
		wb(1'b0, OFS_STAT, 32'hC1, 32'hC1);
		rx_p <= 1'b1;
		@(posedge mclk);
		rx_p <= 1'b0;
		wait_poll(n_poll + 1);
		chk(32'(t inside {[16:28]}), 32'h1);
		chk(32'(n_smp), 32'h1);
		wb(1'b1, OFS_CMD, 32'h1, 32'h0);
		wb(1'b0, OFS_STAT, 32'h40, 32'hC1);
		report_and_stop;
	end
endmodule : tb_sptc_top
`default_nettype wire
